// file: hdl/psr_regs.sv
`timescale 1ns/100ps
// How it works
// - page pointer bits 15:8 at 003h, 23:16 at 004h, read/write, reset zero
// - page pointer bits 7:0 held at 002h, read/write, reset zero
// - pointer 680000h maps first channel main page, 680100h second channel
// - pointer 610000h maps first channel function page, 610100h second channel
// - pointer 690000h maps the shared serial-link page
// - wire-mode bit 0: 0 four-wire, 1 three-wire with bidirectional data pin
// - converter page select all ones maps converter page, zero leaves it out
// - master page select bit 2 maps the master page
// - power-down bit 4 turns off sysref buffer, later sysref pulses ignored
// - power-down bit 1 turns off second channel
// - second channel power-down acts only when its allow bit is set
// - power-down bit 0 turns off the whole chip
module psr_regs (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        sysref_in,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             three_wire,
  output logic             main_first,
  output logic             main_second,
  output logic             func_first,
  output logic             func_second,
  output logic             link_page,
  output logic             conv_page,
  output logic             master_page,
  output logic             sysref_buffer_off,
  output logic             second_channel_off,
  output logic             whole_chip_off,
  output logic             sysref_pulse
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // slot number for each stored offset, 0 for unmapped offsets and for 039h
  function automatic logic [2:0] psr_slot(input logic [11:0] a);
    case (a)
      psr_pkg::OFS_PAGE_LOW:   psr_slot = 3'h1;
      psr_pkg::OFS_PAGE_MID:   psr_slot = 3'h2;
      psr_pkg::OFS_PAGE_HIGH:  psr_slot = 3'h3;
      psr_pkg::OFS_WIRE_MODE:  psr_slot = 3'h4;
      psr_pkg::OFS_CONV_PAGE:  psr_slot = 3'h5;
      psr_pkg::OFS_MSTR_PAGE:  psr_slot = 3'h6;
      psr_pkg::OFS_POWER_DOWN: psr_slot = 3'h7;
      default:                 psr_slot = 3'h0;
    endcase
  endfunction

  // reserved bits are stored as zero so they read back zero
  function automatic logic [7:0] psr_mask(input logic [2:0] s);
    case (s)
      3'h4:    psr_mask = psr_pkg::MASK_WIRE_MODE;
      3'h6:    psr_mask = psr_pkg::MASK_MSTR_PAGE;
      3'h7:    psr_mask = psr_pkg::MASK_POWER_DOWN;
      3'h0:    psr_mask = 8'h00;
      default: psr_mask = 8'hFF;
    endcase
  endfunction

  logic [2:0]  slot;
  logic [7:0]  mem_rd;
  logic [63:0] mem_all;
  logic        allow_hit;

  assign slot      = psr_slot(addr);
  assign allow_hit = (addr == psr_pkg::OFS_CH_OFF_EN);

  // ---------------------------------------------------------------
  // register store
  // ---------------------------------------------------------------
  psr_regmem #(
    .DEPTH    (psr_pkg::NUM_REGS)
  ) u_mem (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .wr_en    (wr_stb && (slot != 3'h0)),
    .wr_slot  (slot),
    .wr_data  (wr_data & psr_mask(slot)),
    .rd_slot  (slot),
    .rd_data  (mem_rd),
    .all_data (mem_all)
  );

  typedef struct packed {
    logic [7:0] allow_reg;
    logic       rd_pend;
    logic       rd_allow;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic [10:0] outs;
    logic       sysref_d;
    logic       sysref_pulse;
  } psr_state_t;

  psr_state_t st;
  psr_state_t next_st;

  logic [23:0] ptr;
  logic [7:0]  wire_r;
  logic [7:0]  conv_r;
  logic [7:0]  mstr_r;
  logic [7:0]  pdn_r;

  assign ptr    = {mem_all[31:24], mem_all[23:16], mem_all[15:8]};
  assign wire_r = mem_all[39:32];
  assign conv_r = mem_all[47:40];
  assign mstr_r = mem_all[55:48];
  assign pdn_r  = mem_all[63:56];

  // ---------------------------------------------------------------
  // decoded controls and read path
  // ---------------------------------------------------------------
  // outputs lag the register store by one cycle, all from flops
  always_comb
  begin
    next_st          = st;
    next_st.rd_valid = st.rd_pend;
    next_st.rd_pend  = rd_stb;
    next_st.rd_allow = rd_stb && allow_hit;
    if (st.rd_pend)
    begin
      // memory data is ready one cycle after the strobe
      next_st.rd_data = st.rd_allow ? st.allow_reg : mem_rd;
    end
    if (wr_stb && allow_hit)
    begin
      next_st.allow_reg = wr_data & psr_pkg::MASK_CH_OFF_EN;
    end
    next_st.outs[0]  = wire_r[psr_pkg::WIRE3_BIT];
    next_st.outs[1]  = (ptr == psr_pkg::PG_MAIN_FIRST);
    next_st.outs[2]  = (ptr == psr_pkg::PG_MAIN_SECOND);
    next_st.outs[3]  = (ptr == psr_pkg::PG_FUNC_FIRST);
    next_st.outs[4]  = (ptr == psr_pkg::PG_FUNC_SECOND);
    next_st.outs[5]  = (ptr == psr_pkg::PG_LINK);
    // only the full all-ones code maps the page; other codes do nothing
    next_st.outs[6]  = (conv_r == psr_pkg::CONV_PAGE_ON);
    next_st.outs[7]  = mstr_r[psr_pkg::MSTR_SEL_BIT];
    next_st.outs[8]  = pdn_r[psr_pkg::SYSREF_OFF_BIT];
    next_st.outs[9]  = pdn_r[psr_pkg::SECOND_OFF_BIT]
                       && st.allow_reg[psr_pkg::OFF_ALLOW_BIT];
    next_st.outs[10] = pdn_r[psr_pkg::WHOLE_OFF_BIT];
    // sysref edge passes only while the buffer is powered
    next_st.sysref_d     = sysref_in;
    next_st.sysref_pulse = sysref_in && !st.sysref_d
                           && !pdn_r[psr_pkg::SYSREF_OFF_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data            = st.rd_data;
  assign rd_valid           = st.rd_valid;
  assign three_wire         = st.outs[0];
  assign main_first         = st.outs[1];
  assign main_second        = st.outs[2];
  assign func_first         = st.outs[3];
  assign func_second        = st.outs[4];
  assign link_page          = st.outs[5];
  assign conv_page          = st.outs[6];
  assign master_page        = st.outs[7];
  assign sysref_buffer_off  = st.outs[8];
  assign second_channel_off = st.outs[9];
  assign whole_chip_off     = st.outs[10];
  assign sysref_pulse       = st.sysref_pulse;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_write_pdn;
    wr_stb && (addr == psr_pkg::OFS_POWER_DOWN);
  endsequence

  chk_page_mid_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_stb && addr == psr_pkg::OFS_PAGE_MID ##2 rd_stb && addr == psr_pkg::OFS_PAGE_MID
    |-> ##2 rd_valid && rd_data == $past(wr_data, 4))
    else $error("mid page byte readback wrong");
  chk_page_low_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_stb && addr == psr_pkg::OFS_PAGE_LOW |=> mem_all[15:8] == $past(wr_data))
    else $error("low page byte not stored");
  chk_main_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptr == psr_pkg::PG_MAIN_SECOND |=> main_second && !main_first)
    else $error("main page decode wrong");
  chk_func_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptr == psr_pkg::PG_FUNC_FIRST |=> func_first && !func_second)
    else $error("function page decode wrong");
  chk_link_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptr != psr_pkg::PG_LINK |=> !link_page)
    else $error("link page decode wrong");
  chk_wire_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_stb && addr == psr_pkg::OFS_WIRE_MODE |-> ##2 three_wire == $past(wr_data[0], 2))
    else $error("wire mode not applied");
  chk_conv_page: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv_r != psr_pkg::CONV_PAGE_ON |=> !conv_page)
    else $error("converter page wrongly mapped");
  chk_master_page: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_stb && addr == psr_pkg::OFS_MSTR_PAGE |-> ##2 master_page == $past(wr_data[2], 2))
    else $error("master page select not applied");
  chk_sysref_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pdn_r[psr_pkg::SYSREF_OFF_BIT] |=> !sysref_pulse)
    else $error("sysref passed while buffer off");
  chk_second_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_write_pdn ##1 !st.allow_reg[psr_pkg::OFF_ALLOW_BIT] |=> !second_channel_off)
    else $error("second channel off without allow");
  chk_whole_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_write_pdn |-> ##2 whole_chip_off == $past(wr_data[0], 2))
    else $error("whole chip power-down not applied");
endmodule

// file: common/psr_pkg.sv
package psr_pkg;
  // register offsets on the serial configuration bus
  localparam logic [11:0] OFS_PAGE_LOW   = 12'h002;
  localparam logic [11:0] OFS_PAGE_MID   = 12'h003;
  localparam logic [11:0] OFS_PAGE_HIGH  = 12'h004;
  localparam logic [11:0] OFS_WIRE_MODE  = 12'h010;
  localparam logic [11:0] OFS_CONV_PAGE  = 12'h011;
  localparam logic [11:0] OFS_MSTR_PAGE  = 12'h012;
  localparam logic [11:0] OFS_POWER_DOWN = 12'h020;
  localparam logic [11:0] OFS_CH_OFF_EN  = 12'h039;
  // field positions
  localparam int WIRE3_BIT       = 0;
  localparam int MSTR_SEL_BIT    = 2;
  localparam int SYSREF_OFF_BIT  = 4;
  localparam int SECOND_OFF_BIT  = 1;
  localparam int WHOLE_OFF_BIT   = 0;
  localparam int OFF_ALLOW_BIT   = 1;
  // writable masks per register
  localparam logic [7:0] MASK_WIRE_MODE  = 8'h01;
  localparam logic [7:0] MASK_MSTR_PAGE  = 8'h04;
  localparam logic [7:0] MASK_POWER_DOWN = 8'h17;
  localparam logic [7:0] MASK_CH_OFF_EN  = 8'h07;
  // page pointer codes and selects
  localparam logic [23:0] PG_MAIN_FIRST  = 24'h680000;
  localparam logic [23:0] PG_MAIN_SECOND = 24'h680100;
  localparam logic [23:0] PG_FUNC_FIRST  = 24'h610000;
  localparam logic [23:0] PG_FUNC_SECOND = 24'h610100;
  localparam logic [23:0] PG_LINK        = 24'h690000;
  localparam logic [7:0]  CONV_PAGE_ON   = 8'hFF;
  localparam logic [7:0]  RESET_VAL      = 8'h00;
  localparam int          NUM_REGS       = 8;
endpackage

// file: hdl/psr_regmem.sv
`timescale 1ns/100ps
// small register store, one byte per slot, read data registered
module psr_regmem #(
  parameter int DEPTH = 8
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_slot,
  input  wire logic [7:0]               wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_slot,
  output logic      [7:0]               rd_data,
  output logic      [DEPTH*8-1:0]       all_data
);
  typedef struct packed {
    logic [DEPTH*8-1:0] mem;
    logic [7:0]         rd;
  } psr_mem_t;

  psr_mem_t cur;
  psr_mem_t next_cur;

  // write one slot, register the read slot
  always_comb
  begin
    next_cur = cur;
    if (wr_en)
    begin
      next_cur.mem[wr_slot*8 +: 8] = wr_data;
    end
    next_cur.rd = next_cur.mem[rd_slot*8 +: 8];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign rd_data  = cur.rd;
  assign all_data = cur.mem;
endmodule

// file: dv/psr_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host side of the configuration bus
// ----------------------------------------
module psr_host (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_valid,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic      [11:0] addr,
  output logic      [7:0]  wr_data
);
  logic conv_on = 1'b0;
  logic mstr_on = 1'b0;

  // bus idle from time zero
  initial
  begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 12'h000;
    wr_data = 8'h00;
  end

  // one strobe cycle; lines scrambled afterwards so stale values never pass
  task automatic put(input logic [11:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk);
    #1;
    addr = a;
    wr_data = d;
    wr_stb = w;
    rd_stb = ~w;
    @(posedge sys_clk);
    #1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask

  // reserved bits sent as zero, the two page selects never on together
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == psr_pkg::OFS_WIRE_MODE) ? psr_pkg::MASK_WIRE_MODE :
        (a == psr_pkg::OFS_MSTR_PAGE) ? psr_pkg::MASK_MSTR_PAGE :
        (a == psr_pkg::OFS_POWER_DOWN) ? psr_pkg::MASK_POWER_DOWN :
        (a == psr_pkg::OFS_CH_OFF_EN) ? psr_pkg::MASK_CH_OFF_EN : 8'hFF;
    if (a == psr_pkg::OFS_CONV_PAGE && d != 8'h00 && mstr_on)
      put(psr_pkg::OFS_MSTR_PAGE, 8'h00, 1'b1);
    if (a == psr_pkg::OFS_MSTR_PAGE && d[2] && conv_on)
      put(psr_pkg::OFS_CONV_PAGE, 8'h00, 1'b1);
    put(a, d & m, 1'b1);
    // only a page-select write can clear the other select
    conv_on = (a == psr_pkg::OFS_CONV_PAGE) ? (d != 8'h00) :
              (a == psr_pkg::OFS_MSTR_PAGE && d[2]) ? 1'b0 : conv_on;
    mstr_on = (a == psr_pkg::OFS_MSTR_PAGE) ? d[2] :
              (a == psr_pkg::OFS_CONV_PAGE && d != 8'h00) ? 1'b0 : mstr_on;
  endtask

  // read: answer taken within a bounded span, else left unknown
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    d = 8'hXX;
    put(a, 8'h00, 1'b0);
    repeat (4)
    begin
      if (rd_valid === 1'b1)
        d = rd_data;
      @(posedge sys_clk);
      #1;
    end
  endtask
endmodule

// file: dv/psr_regs_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// register bank bench
// ----------------------------------------
module psr_regs_tb;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sysref_in = 1'b0;
  logic        wr_stb, rd_stb, rd_valid, three_wire, main_first, main_second;
  logic        func_first, func_second, link_page, conv_page, master_page;
  logic        sysref_buffer_off, second_channel_off, whole_chip_off, sysref_pulse;
  logic [11:0] addr;
  logic [7:0]  wr_data, rd_data, got;
  logic [7:0]  pg, pd;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          pulses = 0;
  int          n;
  logic [11:0] regs [8] = '{12'h002, 12'h003, 12'h004, 12'h010,
                            12'h011, 12'h012, 12'h020, 12'h039};
  logic [23:0] codes [6] = '{24'h680000, 24'h680100, 24'h610000,
                             24'h610100, 24'h690000, 24'h680001};
  logic [7:0]  onehot [6] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};

  // output groups for compact compares
  assign pg = {3'h0, main_first, main_second, func_first, func_second, link_page};
  assign pd = {2'h0, three_wire, conv_page, master_page, sysref_buffer_off,
               second_channel_off, whole_chip_off};

  always #5 sys_clk = ~sys_clk;

  // count sysref pulses let through
  always @(posedge sys_clk)
    if (sysref_pulse === 1'b1)
      pulses <= pulses + 1;

  psr_regs u_psr_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .addr(addr), .wr_data(wr_data), .sysref_in(sysref_in),
    .rd_data(rd_data), .rd_valid(rd_valid), .three_wire(three_wire),
    .main_first(main_first), .main_second(main_second), .func_first(func_first),
    .func_second(func_second), .link_page(link_page), .conv_page(conv_page),
    .master_page(master_page), .sysref_buffer_off(sysref_buffer_off),
    .second_channel_off(second_channel_off), .whole_chip_off(whole_chip_off),
    .sysref_pulse(sysref_pulse));
  psr_host u_psr_host (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wr_data(wr_data));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      $display("[ERR] %0t got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // write, then let the two-cycle update land
  task automatic wrs(input logic [11:0] a, input logic [7:0] d);
    u_psr_host.wr(a, d);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    u_psr_host.rd(a, got);
    chk(got, e);
  endtask

  // one sysref edge, held a few cycles
  task automatic sysref_edge;
    sysref_in = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    sysref_in = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    foreach (regs[i]) rdc(regs[i], 8'h00);
    chk(pd | pg, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      u_psr_host.wr(12'h004, codes[i][23:16]);
      u_psr_host.wr(12'h003, codes[i][15:8]);
      wrs(12'h002, codes[i][7:0]);
      chk(pg, onehot[i]);
      rdc(12'h004, codes[i][23:16]);
      rdc(12'h002, codes[i][7:0]);
    end
    // a read right behind a write must already see the new byte
    u_psr_host.wr(12'h003, 8'hA5);
    rdc(12'h003, 8'hA5);
    wrs(12'h010, 8'hFF);
    chk(pd, 8'h20);
    rdc(12'h010, 8'h01);
    wrs(12'h010, 8'h00);
    wrs(12'h011, 8'h7F);
    chk(pd, 8'h00);
    wrs(12'h011, 8'hFF);
    chk(pd, 8'h10);
    wrs(12'h012, 8'hFF);
    chk(pd, 8'h08);
    rdc(12'h011, 8'h00);
    wrs(12'h020, 8'h01);
    chk(pd, 8'h09);
    wrs(12'h020, 8'h02);
    chk(pd, 8'h08);
    wrs(12'h039, 8'h02);
    chk(pd, 8'h0A);
    wrs(12'h020, 8'h10);
    chk(pd, 8'h0C);
    n = pulses;
    sysref_edge();
    chk(8'(pulses - n), 8'h00);
    wrs(12'h020, 8'h00);
    n = pulses;
    sysref_edge();
    chk(8'(pulses - n), 8'h01);
    wrs(12'h005, 8'hAA);
    rdc(12'h005, 8'h00);
    // mid-run reset with master page and allow bit set must clear all again
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    foreach (regs[i]) rdc(regs[i], 8'h00);
    chk(pd | pg, 8'h00);
    end_sim();
  end

  // watchdog far beyond the few hundred cycles the tests take
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule
